// ==== hdl/nvs_sequencer.v ====
// Sequencer for nonvolatile save, restore and low-power modes.
`timescale 1ns/10ps
`include "nvs_consts.vh"
module nvs_sequencer #(
   parameter CYC_RECALL_UP = `NVS_CYC_RECALL_UP,
   parameter CYC_STORE     = `NVS_CYC_STORE,
   parameter CYC_RECALL    = `NVS_CYC_RECALL,
   parameter CYC_SS        = `NVS_CYC_SS,
   parameter CYC_HIB_ENTRY = `NVS_CYC_HIB_ENTRY,
   parameter CYC_WAKE      = `NVS_CYC_WAKE,
   parameter CYC_RESUME    = `NVS_CYC_RESUME
) (
   // Clock and reset
   input  wire core_clk,
   input  wire reset_n,
   // Supply monitors, asynchronous
   input  wire vcc_ok,
   input  wire power_fail,
   // Hardware save pin, open drain
   input  wire hw_save_busy_pin_in,
   output reg  hw_save_busy_pin_out,
   output reg  hw_save_busy_pin_oe,
   // Decoded commands from the serial front end, one-cycle pulses
   input  wire sw_store_cmd,
   input  wire sw_recall_cmd,
   input  wire autosave_en_cmd,
   input  wire autosave_dis_cmd,
   input  wire hibernate_enter_cmd,
   input  wire sleep_cmd,
   input  wire sram_write_done,
   // Chip select, asynchronous pin
   input  wire cs_n,
   // Status
   output reg  sram_access_en,
   output reg  nv_busy,
   output reg  nv_store_active,
   output reg  nv_recall_active,
   output reg  hibernate_mode,
   output reg  sleep_mode,
   output reg  autosave_enabled
);
   localparam [3:0] ST_OFF    = 4'h0;
   localparam [3:0] ST_RUP    = 4'h1;
   localparam [3:0] ST_IDLE   = 4'h2;
   localparam [3:0] ST_DLY    = 4'h3;
   localparam [3:0] ST_STORE  = 4'h4;
   localparam [3:0] ST_RECALL = 4'h5;
   localparam [3:0] ST_SS     = 4'h6;
   localparam [3:0] ST_HIBIN  = 4'h7;
   localparam [3:0] ST_HIB    = 4'h8;
   localparam [3:0] ST_WAKE   = 4'h9;
   localparam [3:0] ST_RESUME = 4'ha;

   localparam [1:0] OP_STORE  = 2'h0;
   localparam [1:0] OP_RECALL = 2'h1;
   localparam [1:0] OP_SS     = 2'h2;

   wire [3:0] sync_lv;
   wire       vcc_ok_s;
   wire       pfail_s;
   wire       pin_s;
   wire       cs_n_s;

   nvs_sync #(.W(4)) u_sync (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .async_in ({vcc_ok, power_fail, hw_save_busy_pin_in, cs_n}),
      .sync_out (sync_lv)
   );
   assign vcc_ok_s = sync_lv[3];
   assign pfail_s  = sync_lv[2];
   assign pin_s    = sync_lv[1];
   assign cs_n_s   = sync_lv[0];

   function [`NVS_CNT_W-1:0] cyc;
      input integer n;
      begin
         cyc = (n < 1) ? {{(`NVS_CNT_W-1){1'b0}}, 1'b1} : n[`NVS_CNT_W-1:0];
      end
   endfunction

   reg [3:0]             state_ff, nxt_state;
   reg [`NVS_CNT_W-1:0]  cnt_ff, nxt_cnt;
   reg [1:0]             op_ff, nxt_op;
   reg                   dirty_ff, nxt_dirty;
   reg                   auto_ff, nxt_auto;
   reg                   sleep_arm_ff, nxt_sleep_arm;
   reg                   sleep_ff, nxt_sleep;
   reg                   pin_d_ff;
   reg                   pfail_d_ff;
   reg                   cs_d_ff;
   reg                   drive_ff, nxt_drive;
   wire                  pin_fall;
   wire                  pfail_rise;
   wire                  cs_rise;
   wire                  quiet;

   assign pin_fall   = pin_d_ff & ~pin_s & ~drive_ff;
   assign pfail_rise = pfail_s & ~pfail_d_ff;
   assign cs_rise    = cs_n_s & ~cs_d_ff;
   assign quiet      = (state_ff == ST_IDLE);

   always @* begin
      nxt_state     = state_ff;
      nxt_cnt       = cnt_ff;
      nxt_op        = op_ff;
      nxt_dirty     = dirty_ff;
      nxt_auto      = auto_ff;
      nxt_sleep_arm = sleep_arm_ff;
      nxt_sleep     = sleep_ff;
      nxt_drive     = drive_ff;
      if (sram_write_done && quiet && vcc_ok_s) begin
         nxt_dirty = 1'b1;
      end
      if (!vcc_ok_s) begin
         nxt_state = ST_OFF;
         nxt_drive = 1'b0;
      end else begin
         case (state_ff)
            ST_OFF: begin
               nxt_state = ST_RUP;
               nxt_cnt   = cyc(CYC_RECALL_UP);
               nxt_drive = 1'b1;
            end
            ST_RUP: begin
               // Restore right after supply comes up; done bounded by count.
               if (cnt_ff == 1) begin
                  nxt_state = ST_IDLE;
                  nxt_dirty = 1'b0;
                  nxt_drive = 1'b0;
               end else begin
                  nxt_cnt = cnt_ff - 1'b1;
               end
            end
            ST_IDLE: begin
               if ((pfail_rise && auto_ff) || pin_fall) begin
                  if (dirty_ff) begin
                     nxt_state = ST_DLY;
                     nxt_op    = OP_STORE;
                     nxt_cnt   = cyc(`NVS_CYC_DELAY);
                  end
               end else if (sw_store_cmd || sw_recall_cmd || autosave_en_cmd || autosave_dis_cmd) begin
                  nxt_state = ST_DLY;
                  nxt_op    = sw_store_cmd ? OP_STORE : (sw_recall_cmd ? OP_RECALL : OP_SS);
                  nxt_cnt   = cyc(`NVS_CYC_DELAY);
                  if (autosave_en_cmd) begin
                     nxt_auto = 1'b1;
                  end else if (autosave_dis_cmd) begin
                     nxt_auto = 1'b0;
                  end
               end else if (hibernate_enter_cmd) begin
                  nxt_state = ST_HIBIN;
                  nxt_cnt   = cyc(CYC_HIB_ENTRY);
               end else if (sleep_cmd) begin
                  nxt_sleep_arm = 1'b1;
               end
               if (cs_rise) begin
                  // Sleep takes effect at the select release after the command, and the
                  // next select release wakes it so the following selection proceeds.
                  if (sleep_ff) begin
                     nxt_sleep = 1'b0;
                  end else if (sleep_arm_ff) begin
                     nxt_sleep     = 1'b1;
                     nxt_sleep_arm = 1'b0;
                  end
               end
            end
            ST_DLY: begin
               // Access stays open for the trigger delay before gating.
               if (cnt_ff == 1) begin
                  nxt_drive = 1'b1;
                  case (op_ff)
                     OP_STORE:  begin nxt_state = ST_STORE;  nxt_cnt = cyc(CYC_STORE);  end
                     OP_RECALL: begin nxt_state = ST_RECALL; nxt_cnt = cyc(CYC_RECALL); end
                     default:   begin nxt_state = ST_SS;     nxt_cnt = cyc(CYC_SS);     end
                  endcase
               end else begin
                  nxt_cnt = cnt_ff - 1'b1;
               end
            end
            ST_STORE, ST_RECALL, ST_SS: begin
               if (cnt_ff == 1) begin
                  nxt_drive = 1'b0;
                  nxt_dirty = 1'b0;
                  nxt_state = ST_RESUME;
                  nxt_cnt   = cyc(CYC_RESUME);
               end else begin
                  nxt_cnt = cnt_ff - 1'b1;
               end
            end
            ST_RESUME: begin
               // Wait for the pin to read high, bounded by the resume time.
               if (pin_s || cnt_ff == 1) begin
                  nxt_state = ST_IDLE;
               end else begin
                  nxt_cnt = cnt_ff - 1'b1;
               end
            end
            ST_HIBIN: begin
               if (cnt_ff == 1) begin
                  nxt_state = ST_HIB;
               end else begin
                  nxt_cnt = cnt_ff - 1'b1;
               end
            end
            ST_HIB: begin
               // Chip select read low is the wake-up request.
               if (!cs_n_s) begin
                  nxt_state = ST_WAKE;
                  nxt_cnt   = cyc(CYC_WAKE);
               end
            end
            ST_WAKE: begin
               if (cnt_ff == 1) begin
                  nxt_state = ST_IDLE;
               end else begin
                  nxt_cnt = cnt_ff - 1'b1;
               end
            end
            default: begin
               nxt_state = ST_OFF;
            end
         endcase
      end
   end

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff             <= ST_OFF;
         cnt_ff               <= {`NVS_CNT_W{1'b0}};
         op_ff                <= OP_STORE;
         dirty_ff             <= 1'b0;
         auto_ff              <= 1'b1;
         sleep_arm_ff         <= 1'b0;
         sleep_ff             <= 1'b0;
         drive_ff             <= 1'b0;
         pin_d_ff             <= 1'b1;
         pfail_d_ff           <= 1'b0;
         cs_d_ff              <= 1'b1;
         hw_save_busy_pin_out <= 1'b0;
         hw_save_busy_pin_oe  <= 1'b0;
         sram_access_en       <= 1'b0;
         nv_busy              <= 1'b1;
         nv_store_active      <= 1'b0;
         nv_recall_active     <= 1'b0;
         hibernate_mode       <= 1'b0;
         sleep_mode           <= 1'b0;
         autosave_enabled     <= 1'b1;
      end else begin
         state_ff             <= nxt_state;
         cnt_ff               <= nxt_cnt;
         op_ff                <= nxt_op;
         dirty_ff             <= nxt_dirty;
         auto_ff              <= nxt_auto;
         sleep_arm_ff         <= nxt_sleep_arm;
         sleep_ff             <= nxt_sleep;
         drive_ff             <= nxt_drive;
         pin_d_ff             <= pin_s;
         pfail_d_ff           <= pfail_s;
         cs_d_ff              <= cs_n_s;
         hw_save_busy_pin_out <= 1'b0;
         hw_save_busy_pin_oe  <= nxt_drive;
         // Access open only in idle or the trigger delay, and with good supply.
         sram_access_en       <= vcc_ok_s && (nxt_state == ST_IDLE || nxt_state == ST_DLY);
         nv_busy              <= !(nxt_state == ST_IDLE || nxt_state == ST_DLY);
         nv_store_active      <= (nxt_state == ST_STORE);
         nv_recall_active     <= (nxt_state == ST_RECALL) || (nxt_state == ST_RUP);
         hibernate_mode       <= (nxt_state == ST_HIB);
         sleep_mode           <= nxt_sleep;
         autosave_enabled     <= nxt_auto;
      end
   end
endmodule

// ==== common/nvs_consts.vh ====
// Constants for the nonvolatile save and restore sequencer.
// How it works
// - Power-up restore completes within 20 ms after supply rises above threshold.
// - Power-loss or pin save is skipped when no write since last cycle.
// - Memory access stays enabled up to 25 ns after a save trigger.
// - Host reads and writes ignored during save, restore or low supply.
// - Host I/O locked until done; save within 8 ms, restore within 500 us.
// - Autosave enable or disable command acted on within 500 us; supply must stay high.
// - Hibernate entered within 8 ms after the hibernate command.
// - Wake from hibernate and ready within 20 ms.
// - Sleep entered with no delay when chip select rises after sleep command.
// - Sleep exited with no delay when chip select rises.
// - Active again within 5 us after save pin returns high.
// - Power-loss save starts when detector reports supply below 2.60 V.
`ifndef NVS_CONSTS_VH
`define NVS_CONSTS_VH
`define NVS_CLK_MHZ        40
`define NVS_T_RECALL_UP_MS 20
`define NVS_T_STORE_MS     8
`define NVS_T_DELAY_NS     25
`define NVS_T_RECALL_US    500
`define NVS_T_SS_US        500
`define NVS_T_HIB_ENTRY_MS 8
`define NVS_T_WAKE_MS      20
`define NVS_T_RESUME_NS    5000
`define NVS_T_PULSE_NS     600
// Cycle counts: nanosecond times round down.
`define NVS_CYC_RECALL_UP  (`NVS_T_RECALL_UP_MS * 1000 * `NVS_CLK_MHZ)
`define NVS_CYC_STORE      (`NVS_T_STORE_MS * 1000 * `NVS_CLK_MHZ)
`define NVS_CYC_DELAY      ((`NVS_T_DELAY_NS * `NVS_CLK_MHZ) / 1000)
`define NVS_CYC_RECALL     (`NVS_T_RECALL_US * `NVS_CLK_MHZ)
`define NVS_CYC_SS         (`NVS_T_SS_US * `NVS_CLK_MHZ)
`define NVS_CYC_HIB_ENTRY  (`NVS_T_HIB_ENTRY_MS * 1000 * `NVS_CLK_MHZ)
`define NVS_CYC_WAKE       (`NVS_T_WAKE_MS * 1000 * `NVS_CLK_MHZ)
`define NVS_CYC_RESUME     ((`NVS_T_RESUME_NS * `NVS_CLK_MHZ) / 1000)
`define NVS_CNT_W          20
`endif

// ==== hdl/nvs_sync.v ====
// Two-flip-flop synchroniser for asynchronous pin levels.
`timescale 1ns/10ps
module nvs_sync #(
   parameter W = 1
) (
   // Clock and reset
   input  wire         core_clk,
   input  wire         reset_n,
   // Levels
   input  wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);
   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_ff <= {W{1'b0}};
         sync_ff <= {W{1'b0}};
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end
   assign sync_out = sync_ff;
endmodule

// ==== test/nvs_host_model.sv ====
// Host side model: pulled-up save pin and chip select.
`timescale 1ns/10ps
module nvs_host_model (
   // Clock
   input  wire  core_clk,
   // Save pin
   input  wire  dev_oe,
   output wire  pin_level,
   // Select
   output logic cs_n
);
   logic host_low;
   // The pin has a pull-up, so it reads high unless a party pulls it down.
   assign pin_level = !(dev_oe || host_low);
   initial begin
      host_low = 1'b0;
      cs_n     = 1'b1;
   end
   // Four cycles stay well inside the pulse limit yet pass the synchroniser.
   task automatic save_pulse();
      @(posedge core_clk);
      host_low <= 1'b1;
      repeat (4) @(posedge core_clk);
      host_low <= 1'b0;
   endtask
   task automatic set_cs(input logic v);
      @(posedge core_clk);
      cs_n <= v;
   endtask
endmodule

// ==== test/nvs_sequencer_props.sv ====
// Port checks for the save and restore sequencer.
`timescale 1ns/10ps
module nvs_sequencer_props #(
   parameter CYC_RECALL_UP = 8,
   parameter CYC_STORE     = 8,
   parameter CYC_HIB_ENTRY = 8,
   parameter CYC_WAKE      = 8,
   parameter CYC_RESUME    = 8
) (
   // Clock, reset and inputs
   input wire core_clk,
   input wire reset_n,
   input wire vcc_ok,
   input wire cs_n,
   input wire sw_store_cmd,
   input wire sw_recall_cmd,
   input wire hibernate_enter_cmd,
   // Outputs
   input wire hw_save_busy_pin_oe,
   input wire sram_access_en,
   input wire nv_busy,
   input wire nv_store_active,
   input wire nv_recall_active,
   input wire hibernate_mode
);
   localparam int LZ = CYC_RESUME + 4;
   localparam int HB = CYC_HIB_ENTRY + 4;
   localparam int WK = CYC_WAKE + CYC_RESUME + 6;
   logic [19:0] oe_run_ff;
   wire         idle = sram_access_en && !nv_busy;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // Run length of the busy pull, so long durations need no long repetition.
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         oe_run_ff <= 20'h00000;
      end else begin
         oe_run_ff <= hw_save_busy_pin_oe ? oe_run_ff + 20'h00001 : 20'h00000;
      end
   end
   sequence s_gate;
      sram_access_en ##1 (!sram_access_en && hw_save_busy_pin_oe);
   endsequence
   a_store_gate_late: assert property (sw_store_cmd && idle |=> s_gate ##0 nv_store_active)
      else $error("store start not gated one cycle late");
   a_recall_gate_late: assert property (sw_recall_cmd && idle |=> s_gate ##0 nv_recall_active)
      else $error("recall start not gated one cycle late");
   a_pin_busy_gate: assert property (hw_save_busy_pin_oe |-> nv_busy && !sram_access_en)
      else $error("access open while busy pin pulled");
   a_supply_low_gate: assert property ((!vcc_ok) [*4] |-> !sram_access_en)
      else $error("access open with supply low");
   a_store_max_len: assert property (nv_store_active |-> oe_run_ff <= CYC_STORE)
      else $error("save ran too long");
   a_restore_max_len: assert property (nv_recall_active |-> oe_run_ff <= CYC_RECALL_UP)
      else $error("restore ran too long");
   a_resume_bound: assert property ($fell(hw_save_busy_pin_oe) && vcc_ok |-> ##[1:LZ] (sram_access_en || hibernate_mode))
      else $error("access not back after busy pin released");
   a_hibernate_entry: assert property (hibernate_enter_cmd && idle |-> ##[1:HB] hibernate_mode)
      else $error("hibernate not entered in time");
   a_wake_ready: assert property (hibernate_mode && !cs_n |-> ##[1:WK] sram_access_en)
      else $error("no access after wake");
endmodule
bind nvs_sequencer nvs_sequencer_props #(.CYC_RECALL_UP(CYC_RECALL_UP), .CYC_STORE(CYC_STORE),
   .CYC_HIB_ENTRY(CYC_HIB_ENTRY), .CYC_WAKE(CYC_WAKE), .CYC_RESUME(CYC_RESUME)) i_nvs_sequencer_props (
   .core_clk(core_clk), .reset_n(reset_n),
   .vcc_ok(vcc_ok), .cs_n(cs_n), .sw_store_cmd(sw_store_cmd), .sw_recall_cmd(sw_recall_cmd),
   .hibernate_enter_cmd(hibernate_enter_cmd), .hw_save_busy_pin_oe(hw_save_busy_pin_oe),
   .sram_access_en(sram_access_en), .nv_busy(nv_busy), .nv_store_active(nv_store_active),
   .nv_recall_active(nv_recall_active), .hibernate_mode(hibernate_mode));

// ==== test/nvs_sequencer_tb.sv ====
// Self-checking bench for the save and restore sequencer.
`timescale 1ns/10ps
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin err_total++; $display("[ERR] %s exp %h seen %h", nm, e, a); end end
module nvs_sequencer_tb;
   localparam int RU = 40;
   localparam int ST = 30;
   localparam int RC = 20;
   localparam int SS = 12;
   localparam int HB = 16;
   localparam int WK = 24;
   localparam int LZ = 8;
   logic       core_clk, reset_n, vcc_ok, power_fail, wr_done;
   logic [5:0] cmd_v;
   wire        pin, cs_n, oe, pout, acc, busy, st_act, rc_act, hib, slp, as_en;
   int         err_total, checks_done, n;
   nvs_host_model i_nvs_host_model (.core_clk(core_clk), .dev_oe(oe), .pin_level(pin), .cs_n(cs_n));
   nvs_sequencer #(.CYC_RECALL_UP(RU), .CYC_STORE(ST), .CYC_RECALL(RC), .CYC_SS(SS), .CYC_HIB_ENTRY(HB),
      .CYC_WAKE(WK), .CYC_RESUME(LZ)) i_nvs_sequencer (.core_clk(core_clk), .reset_n(reset_n), .vcc_ok(vcc_ok),
      .power_fail(power_fail), .hw_save_busy_pin_in(pin), .hw_save_busy_pin_out(pout), .hw_save_busy_pin_oe(oe),
      .sw_store_cmd(cmd_v[0]), .sw_recall_cmd(cmd_v[1]), .autosave_en_cmd(cmd_v[2]), .autosave_dis_cmd(cmd_v[3]),
      .hibernate_enter_cmd(cmd_v[4]), .sleep_cmd(cmd_v[5]), .sram_write_done(wr_done), .cs_n(cs_n),
      .sram_access_en(acc), .nv_busy(busy), .nv_store_active(st_act), .nv_recall_active(rc_act),
      .hibernate_mode(hib), .sleep_mode(slp), .autosave_enabled(as_en));
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic end_sim();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   function automatic logic pick(input int sel);
      case (sel)
         0: return acc;
         1: return oe;
         2: return hib;
         default: return slp;
      endcase
   endfunction
   // Bounded wait; a run-out is a mismatch and ends the run.
   task automatic wait_hi(input int sel, input int lim);
      n = 0;
      while (pick(sel) !== 1'b1 && n < lim) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      `CHK("awaited flag", 1'b1, pick(sel))
      if (pick(sel) !== 1'b1) begin
         end_sim();
      end
   endtask
   task automatic pulse(input logic [5:0] c);
      @(posedge core_clk);
      cmd_v <= c;
      @(posedge core_clk);
      cmd_v <= 6'h00;
      #1;
   endtask
   task automatic sram_write();
      @(posedge core_clk);
      wr_done <= 1'b1;
      @(posedge core_clk);
      wr_done <= 1'b0;
   endtask
   // Counts cycles with the busy pull active over a fixed window.
   task automatic count_oe(input int lim);
      n = 0;
      repeat (lim) begin
         @(posedge core_clk);
         #1;
         n += (oe === 1'b1);
      end
   endtask
   // Shared command walk: access stays open one cycle, then closes until done.
   task automatic run_cmd(input logic [5:0] c, input int lim);
      pulse(c);
      `CHK("access in delay", 1'b1, acc)
      @(posedge core_clk);
      #1;
      `CHK("access gated", 1'b0, acc)
      `CHK("busy pin low", 1'b0, pin)
      `CHK("pin drive value", 1'b0, pout)
      `CHK("busy flag", 1'b1, busy)
      wait_hi(0, lim);
   endtask
   task automatic t_power_up();
      wait_hi(1, 8);
      `CHK("restore active", 1'b1, rc_act)
      wait_hi(0, RU + LZ + 6);
   endtask
   task automatic t_sw_ops();
      run_cmd(6'h01, ST + LZ + 4);
      run_cmd(6'h02, RC + LZ + 4);
      run_cmd(6'h08, SS + LZ + 4);
      `CHK("autosave off", 1'b0, as_en)
      // A supply warning with autosave off must not start a save, even with dirty data.
      sram_write();
      power_fail <= 1'b1;
      count_oe(12);
      `CHK("no save with autosave off", 0, n)
      @(posedge core_clk);
      power_fail <= 1'b0;
      repeat (4) @(posedge core_clk);
      run_cmd(6'h04, SS + LZ + 4);
      `CHK("autosave on", 1'b1, as_en)
   endtask
   task automatic t_hw_save();
      i_nvs_host_model.save_pulse();
      count_oe(12);
      `CHK("clean save skipped", 0, n)
      sram_write();
      i_nvs_host_model.save_pulse();
      wait_hi(1, 8);
      `CHK("pin save runs", 1'b1, st_act)
      wait_hi(0, ST + LZ + 6);
   endtask
   task automatic t_power_loss();
      sram_write();
      power_fail <= 1'b1;
      wait_hi(1, 8);
      `CHK("power-loss save", 1'b1, st_act)
      wait_hi(0, ST + LZ + 6);
      @(posedge core_clk);
      power_fail <= 1'b0;
      vcc_ok <= 1'b0;
      repeat (5) @(posedge core_clk);
      #1;
      `CHK("access with supply low", 1'b0, acc)
      @(posedge core_clk);
      vcc_ok <= 1'b1;
      wait_hi(1, 8);
      `CHK("restore again", 1'b1, rc_act)
      wait_hi(0, RU + LZ + 6);
   endtask
   task automatic t_low_power();
      pulse(6'h10);
      wait_hi(2, HB + 4);
      i_nvs_host_model.set_cs(1'b0);
      wait_hi(0, WK + LZ + 8);
      pulse(6'h20);
      i_nvs_host_model.set_cs(1'b1);
      wait_hi(3, 5);
      i_nvs_host_model.set_cs(1'b0);
      i_nvs_host_model.set_cs(1'b1);
      repeat (5) @(posedge core_clk);
      #1;
      `CHK("sleep left", 1'b0, slp)
   endtask
   initial begin
      reset_n = 1'b0;
      vcc_ok = 1'b1;
      power_fail = 1'b0;
      wr_done = 1'b0;
      cmd_v = 6'h00;
      err_total = 0;
      checks_done = 0;
      repeat (3) @(posedge core_clk);
      reset_n <= 1'b1;
      t_power_up();
      t_sw_ops();
      t_hw_save();
      t_power_loss();
      t_low_power();
      end_sim();
   end
endmodule
